// ===== logic/rst_seq_params.svh
// Purpose: shared constants of the reset sequencer: register offsets, field positions, reset values, timing
// Assumes: 100 MHz system clock, 8-bit register bus
// Notes: included by the package and by the design modules
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

// system clock rate and the derived timing counts
`define SYS_CLK_MHZ 100
`define POR_TIMEOUT_MS 100
`define POR_TIMEOUT_CYCLES (`POR_TIMEOUT_MS * 1000 * `SYS_CLK_MHZ)
`define PIN_EXIT_CYCLES 12
`define SRC_EXIT_CYCLES 4
`define TIMER_W 24

// register offsets
`define ADDR_RESET_SOURCE 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0C

// reset source register bits
`define RSF_PIN 0
`define RSF_POR 1
`define RSF_MCD 2
`define RSF_WDT 3
`define RSF_CMP 5
`define RSF_CNV 6

// control register bits
`define CTL_MCD_EN 0
`define CTL_OSC_EXT 1
`define CTL_OSC_FREQ_LO 2
`define CTL_OSC_FREQ_HI 3

// interrupt status bits
`define IRQ_POR_EXIT 0
`define IRQ_PIN_EXIT 1
`define IRQ_SRC_EXIT 2
`define IRQ_BITS 3

// defaults loaded by every reset
`define PORT_LATCH_DEFAULT 8'hFF
`define PC_RESET_VALUE 16'h0000
`define INT_OSC_FREQ_2MHZ 2'h0
`define WDT_INTERVAL_MAX 3'h7

`endif

// ===== logic/rst_seq_pkg.sv
// Purpose: types of the reset sequencer
// Assumes: rst_seq_params.svh supplies the widths
// Notes: state of each module is one packed struct
`include "rst_seq_params.svh"

package rst_seq_pkg;

    typedef enum logic [1:0] {
        ST_POR_HOLD,
        ST_HOLD,
        ST_WAIT,
        ST_RUN
    } rst_state_t;

    typedef struct packed {
        rst_state_t state;
        logic in_reset;
        logic por_cause;
        logic pin_oe;
        logic [7:0] pend_flags;
        logic [7:0] src_flags;
        logic cmp_en;
        logic cnv_en;
        logic mcd_en;
        logic osc_ext;
        logic [1:0] osc_freq;
        logic wdt_en;
        logic [2:0] wdt_interval;
        logic pc_clear;
        logic wdt_restart;
        logic [`IRQ_BITS-1:0] irq_status;
        logic [`IRQ_BITS-1:0] irq_mask;
        logic [7:0] rdata;
    } seq_state_t;

    typedef struct packed {
        logic [`TIMER_W-1:0] count;
    } timer_state_t;

endpackage

// ===== logic/reset_timer.sv
// Purpose: down counter that times the stretch before reset release
// Assumes: load has priority over counting
// Notes: done is high while the count stands at zero and load is low
`timescale 1ns/1ps
`include "rst_seq_params.svh"

module reset_timer
    import rst_seq_pkg::*;
#(
    parameter int WIDTH = `TIMER_W
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic done
);

    timer_state_t t_r;
    timer_state_t t_nxt;

    // load, else count down to zero and stop there
    always_comb
    begin
        t_nxt = t_r;
        if (load)
        begin
            t_nxt.count = load_value;
        end
        else if (t_r.count != '0)
        begin
            t_nxt.count = t_r.count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            t_r <= '0;
        end
        else
        begin
            t_r <= t_nxt;
        end
    end

    assign done = (t_r.count == '0) && !load;

endmodule

// ===== logic/mcu_reset_sequencer.sv
// Purpose: gathers reset requests, holds the core in reset, times the release and records the cause
// Assumes: all inputs synchronous to sys_clk; the reset pin reads low whenever the pin is driven low
// Notes: software registers on a plain strobe port, read data one cycle after the read strobe
`timescale 1ns/1ps
`include "rst_seq_params.svh"

module mcu_reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int unsigned POR_TIMEOUT_CYCLES = `POR_TIMEOUT_CYCLES,
    parameter int unsigned PIN_EXIT_CYCLES = `PIN_EXIT_CYCLES,
    parameter int unsigned SRC_EXIT_CYCLES = `SRC_EXIT_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic supply_below_threshold,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    input wire logic conversion_start_input_n,
    input wire logic comparator0_n,
    input wire logic missing_clock_event,
    input wire logic watchdog_overflow,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic irq,
    output logic core_halt,
    output logic sfr_load_defaults,
    output logic irq_disable,
    output logic timers_disable,
    output logic stack_pointer_reset,
    output logic data_ram_write_block,
    output logic port_latch_force,
    output logic [7:0] port_latch_value,
    output logic pc_clear,
    output logic [15:0] pc_value,
    output logic osc_internal_sel,
    output logic [1:0] osc_freq_sel,
    output logic wdt_enable,
    output logic wdt_restart,
    output logic [2:0] wdt_interval,
    output logic [7:0] reset_source_register
);

    localparam logic [`TIMER_W-1:0] POR_LOAD = `TIMER_W'(POR_TIMEOUT_CYCLES);
    localparam logic [`TIMER_W-1:0] PIN_LOAD = `TIMER_W'(PIN_EXIT_CYCLES);
    localparam logic [`TIMER_W-1:0] SRC_LOAD = `TIMER_W'(SRC_EXIT_CYCLES);

    // power-up starts as a supply-monitor reset with the pin driven
    localparam seq_state_t SEQ_RESET = '{
        state: ST_POR_HOLD,
        in_reset: 1'b1,
        por_cause: 1'b1,
        pin_oe: 1'b1,
        pend_flags: 8'h02,
        src_flags: 8'h00,
        cmp_en: 1'b0,
        cnv_en: 1'b0,
        mcd_en: 1'b0,
        osc_ext: 1'b0,
        osc_freq: `INT_OSC_FREQ_2MHZ,
        wdt_en: 1'b1,
        wdt_interval: `WDT_INTERVAL_MAX,
        pc_clear: 1'b0,
        wdt_restart: 1'b0,
        irq_status: '0,
        irq_mask: '0,
        rdata: 8'h00
    };

    seq_state_t s_r;
    seq_state_t s_nxt;
    logic timer_load;
    logic [`TIMER_W-1:0] timer_value;
    logic timer_done;

    logic pin_req;
    logic level_req;
    logic [7:0] req_flags;
    logic sw_por;
    logic wr_src;
    logic wr_ctl;
    logic wr_sts;
    logic wr_msk;

    // flags of the sources that request reset right now; the pin only counts when we do not drive it
    function automatic logic [7:0] source_flags(
        input logic pin,
        input logic cnv,
        input logic cmp,
        input logic mcd,
        input logic wdt
    );
        logic [7:0] f;
        f = 8'h00;
        f[`RSF_PIN] = pin;
        f[`RSF_CNV] = cnv;
        f[`RSF_CMP] = cmp;
        f[`RSF_MCD] = mcd;
        f[`RSF_WDT] = wdt;
        return f;
    endfunction

    // address decode of the write strobe
    function automatic logic hit(
        input logic strobe,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        return strobe && (addr == offset);
    endfunction

    // request terms: OR of every enabled source
    always_comb
    begin
        pin_req = !rst_pin_in && !s_r.pin_oe;
        req_flags = source_flags(pin_req,
                                 s_r.cnv_en && !conversion_start_input_n,
                                 s_r.cmp_en && !comparator0_n,
                                 s_r.mcd_en && missing_clock_event,
                                 watchdog_overflow);
        level_req = req_flags[`RSF_PIN] || req_flags[`RSF_CNV] || req_flags[`RSF_CMP];
        wr_src = hit(bus_wr, bus_addr, `ADDR_RESET_SOURCE);
        wr_ctl = hit(bus_wr, bus_addr, `ADDR_CONTROL);
        wr_sts = hit(bus_wr, bus_addr, `ADDR_IRQ_STATUS);
        wr_msk = hit(bus_wr, bus_addr, `ADDR_IRQ_MASK);
        sw_por = wr_src && bus_wdata[`RSF_POR] && (s_r.state == ST_RUN);
    end

    // sequencing, register file and defaults
    always_comb
    begin
        s_nxt = s_r;
        timer_load = 1'b0;
        timer_value = SRC_LOAD;
        s_nxt.pc_clear = 1'b0;
        s_nxt.wdt_restart = 1'b0;
        s_nxt.rdata = 8'h00;

        // supply low wins over every other state and source
        if (supply_below_threshold)
        begin
            s_nxt.state = ST_POR_HOLD;
            s_nxt.por_cause = 1'b1;
            s_nxt.pend_flags = 8'h02;
        end
        else
        begin
            case (s_r.state)
                ST_RUN:
                begin
                    if (sw_por)
                    begin
                        s_nxt.state = ST_WAIT;
                        s_nxt.por_cause = 1'b1;
                        s_nxt.pend_flags = 8'h02;
                        timer_load = 1'b1;
                        timer_value = POR_LOAD;
                    end
                    else if (req_flags != 8'h00)
                    begin
                        s_nxt.por_cause = 1'b0;
                        s_nxt.pend_flags = req_flags;
                        if (level_req)
                        begin
                            s_nxt.state = ST_HOLD;
                        end
                        else
                        begin
                            s_nxt.state = ST_WAIT;
                            timer_load = 1'b1;
                            timer_value = SRC_LOAD;
                        end
                    end
                end
                ST_POR_HOLD:
                begin
                    // supply has come back: start the settling timeout
                    s_nxt.state = ST_WAIT;
                    timer_load = 1'b1;
                    timer_value = POR_LOAD;
                end
                ST_HOLD:
                begin
                    s_nxt.pend_flags = s_r.pend_flags | req_flags;
                    if (!level_req)
                    begin
                        s_nxt.state = ST_WAIT;
                        timer_load = 1'b1;
                        timer_value = s_r.pend_flags[`RSF_PIN] ? PIN_LOAD : SRC_LOAD;
                    end
                end
                ST_WAIT:
                begin
                    // a power-on timeout is not cut short or restarted by the weaker sources
                    if (!s_r.por_cause && (req_flags != 8'h00))
                    begin
                        s_nxt.pend_flags = s_r.pend_flags | req_flags;
                        if (level_req)
                        begin
                            s_nxt.state = ST_HOLD;
                        end
                        else
                        begin
                            timer_load = 1'b1;
                            timer_value = SRC_LOAD;
                        end
                    end
                    else if (timer_done)
                    begin
                        s_nxt.state = ST_RUN;
                        s_nxt.pc_clear = 1'b1;
                        s_nxt.wdt_restart = 1'b1;
                        if (s_r.por_cause)
                        begin
                            s_nxt.src_flags = 8'h02;
                            s_nxt.irq_status[`IRQ_POR_EXIT] = 1'b1;
                        end
                        else
                        begin
                            s_nxt.src_flags = s_r.pend_flags & ~8'h02;
                            if (s_r.pend_flags[`RSF_PIN])
                            begin
                                s_nxt.irq_status[`IRQ_PIN_EXIT] = 1'b1;
                            end
                            else
                            begin
                                s_nxt.irq_status[`IRQ_SRC_EXIT] = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    s_nxt.state = ST_POR_HOLD;
                    s_nxt.por_cause = 1'b1;
                    s_nxt.pend_flags = 8'h02;
                end
            endcase
        end

        s_nxt.in_reset = (s_nxt.state != ST_RUN);
        s_nxt.pin_oe = s_nxt.in_reset && s_nxt.por_cause;

        // reset source and control writes take effect only while the core runs
        if (!s_r.in_reset && !s_nxt.in_reset)
        begin
            if (wr_src)
            begin
                s_nxt.cmp_en = bus_wdata[`RSF_CMP];
                s_nxt.cnv_en = bus_wdata[`RSF_CNV];
            end
            if (wr_ctl)
            begin
                s_nxt.mcd_en = bus_wdata[`CTL_MCD_EN];
                s_nxt.osc_ext = bus_wdata[`CTL_OSC_EXT];
                s_nxt.osc_freq = bus_wdata[`CTL_OSC_FREQ_HI:`CTL_OSC_FREQ_LO];
            end
        end

        // every reset puts the configuration except the interrupt mask back to its defaults
        if (s_nxt.in_reset)
        begin
            s_nxt.cmp_en = 1'b0;
            s_nxt.cnv_en = 1'b0;
            s_nxt.mcd_en = 1'b0;
            s_nxt.osc_ext = 1'b0;
            s_nxt.osc_freq = `INT_OSC_FREQ_2MHZ;
            s_nxt.wdt_en = 1'b1;
            s_nxt.wdt_interval = `WDT_INTERVAL_MAX;
        end

        // interrupt status: write one to clear, a new event in the same cycle wins only where its bit was clear before
        if (wr_sts)
        begin
            s_nxt.irq_status = s_nxt.irq_status & ~(bus_wdata[`IRQ_BITS-1:0] & ~(s_nxt.irq_status ^ s_r.irq_status));
        end
        if (wr_msk)
        begin
            s_nxt.irq_mask = bus_wdata[`IRQ_BITS-1:0];
        end

        // read data stand in the cycle after the strobe; unmapped offsets read zero
        if (bus_rd)
        begin
            case (bus_addr)
                `ADDR_RESET_SOURCE:
                begin
                    s_nxt.rdata = s_r.src_flags;
                end
                `ADDR_CONTROL:
                begin
                    s_nxt.rdata = {4'h0, s_r.osc_freq, s_r.osc_ext, s_r.mcd_en};
                end
                `ADDR_IRQ_STATUS:
                begin
                    s_nxt.rdata = {5'h00, s_r.irq_status};
                end
                `ADDR_IRQ_MASK:
                begin
                    s_nxt.rdata = {5'h00, s_r.irq_mask};
                end
                default:
                begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_r <= SEQ_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // release stretch for power-on, pin and the other sources
    reset_timer #(
        .WIDTH(`TIMER_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(timer_load),
        .load_value(timer_value),
        .done(timer_done)
    );

    // core-facing hold levels come from the one registered reset flag; pc_clear is its own registered pulse, the latch and pc values are constants
    assign core_halt = s_r.in_reset;
    assign sfr_load_defaults = s_r.in_reset;
    assign irq_disable = s_r.in_reset;
    assign timers_disable = s_r.in_reset;
    assign stack_pointer_reset = s_r.in_reset;
    assign data_ram_write_block = s_r.in_reset;
    assign port_latch_force = s_r.in_reset;
    assign port_latch_value = `PORT_LATCH_DEFAULT;
    assign pc_clear = s_r.pc_clear;
    assign pc_value = `PC_RESET_VALUE;

    // the pin is only ever pulled low, never driven high
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = s_r.pin_oe;

    assign osc_internal_sel = !s_r.osc_ext;
    assign osc_freq_sel = s_r.osc_freq;
    assign wdt_enable = s_r.wdt_en;
    assign wdt_restart = s_r.wdt_restart;
    assign wdt_interval = s_r.wdt_interval;
    assign reset_source_register = s_r.src_flags;
    assign bus_rdata = s_r.rdata;
    assign irq = |(s_r.irq_status & s_r.irq_mask);

endmodule

// ===== tb/reset_env_model.sv
// Purpose: far side of the sequencer: supply monitor and external reset pin circuitry
// Assumes: reset pin has a weak pull-up, so a released pin reads high
// Notes: the testbench steers the supply level and the external pull through two request inputs
`timescale 1ns/1ps

module reset_env_model
(
    input wire logic sys_clk,
    input wire logic rst_pin_oe,
    input wire logic rst_pin_out,
    input wire logic ext_pull,
    input wire logic supply_low_req,
    output logic rst_pin_in,
    output logic supply_below_threshold
);
    // wired-and of both drivers on the pin; pull-up wins when nobody drives it
    // the sequencer's own level is used, so a wrong drive value shows up on the pin
    assign rst_pin_in = !ext_pull && (rst_pin_oe ? rst_pin_out : 1'b1);

    // monitor output is a clean level, one register after the supply event
    always_ff @(posedge sys_clk)
    begin
        supply_below_threshold <= supply_low_req;
    end
endmodule

// ===== tb/reset_chk.sv
// Purpose: concurrent checks on the sequencer top-level ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: pin-exit stretch of twelve cycles written as two short repetitions
`timescale 1ns/1ps

module reset_chk
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic supply_below_threshold,
    input wire logic rst_pin_in,
    input wire logic rst_pin_oe,
    input wire logic watchdog_overflow,
    input wire logic core_halt,
    input wire logic sfr_load_defaults,
    input wire logic irq_disable,
    input wire logic timers_disable,
    input wire logic stack_pointer_reset,
    input wire logic data_ram_write_block,
    input wire logic port_latch_force,
    input wire logic [7:0] port_latch_value,
    input wire logic pc_clear,
    input wire logic [15:0] pc_value,
    input wire logic osc_internal_sel,
    input wire logic [1:0] osc_freq_sel,
    input wire logic wdt_enable,
    input wire logic wdt_restart,
    input wire logic [2:0] wdt_interval
    ,input wire logic [7:0] reset_source_register
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // exit steps: leaving reset, and a pin release seen while still halted
    sequence s_exit;
        $fell(core_halt);
    endsequence
    sequence s_pin_rel;
        !$past(rst_pin_oe) && $rose(rst_pin_in) && core_halt;
    endsequence
    sequence s_hold12;
        core_halt[*8] ##1 core_halt[*4];
    endsequence

    property p_group; core_halt == sfr_load_defaults && core_halt == port_latch_force && core_halt == irq_disable
        && core_halt == timers_disable && core_halt == stack_pointer_reset && core_halt == data_ram_write_block;
    endproperty
    property p_latch; port_latch_value == 8'hFF; endproperty
    property p_pc; s_exit |-> pc_clear && pc_value == 16'h0000 ##1 !pc_clear; endproperty
    property p_osc; s_exit |-> osc_internal_sel && osc_freq_sel == 2'h0; endproperty
    property p_wdt; s_exit |-> wdt_enable && wdt_restart && wdt_interval == 3'h7; endproperty
    property p_supply; supply_below_threshold |=> core_halt && rst_pin_oe; endproperty
    property p_por_flag; $past(rst_pin_oe) and s_exit |-> reset_source_register == 8'h02; endproperty
    property p_other_flag; !$past(rst_pin_oe) and s_exit |-> !reset_source_register[1]; endproperty
    property p_pin; s_pin_rel |=> s_hold12 ##[1:8] reset_source_register[0]; endproperty
    property p_wdo; watchdog_overflow && !core_halt |=> core_halt; endproperty

    a_group: assert property (p_group) else $error("reset outputs disagree");
    a_latch: assert property (p_latch) else $error("port latch value wrong");
    a_pc: assert property (p_pc) else $error("program counter clear wrong");
    a_osc: assert property (p_osc) else $error("clock default wrong");
    a_wdt: assert property (p_wdt) else $error("watchdog default wrong");
    a_supply: assert property (p_supply) else $error("low supply not held");
    a_por_flag: assert property (p_por_flag) else $error("power-on flags wrong");
    a_other_flag: assert property (p_other_flag) else $error("power-on flag kept");
    a_pin: assert property (p_pin) else $error("pin exit stretch wrong");
    a_wdo: assert property (p_wdo) else $error("overflow did not reset");
endmodule

bind mcu_reset_sequencer reset_chk i_chk (.sys_clk, .reset_n, .supply_below_threshold, .rst_pin_in, .rst_pin_oe,
    .watchdog_overflow, .core_halt, .sfr_load_defaults, .irq_disable, .timers_disable, .stack_pointer_reset,
    .data_ram_write_block, .port_latch_force, .port_latch_value, .pc_clear, .pc_value, .osc_internal_sel,
    .osc_freq_sel, .wdt_enable, .wdt_restart, .wdt_interval, .reset_source_register);

// ===== tb/testbench.sv
// Purpose: self-checking bench for the reset sequencer, one task per scenario
// Assumes: power-on timeout shortened to a few cycles
// Notes: the env model resolves the reset pin and the supply level
`timescale 1ns/1ps

module testbench;
    import rst_seq_pkg::*;
    localparam int POR = 20;
    logic sys_clk, reset_n, ext_pull, supply_low_req, rst_pin_in, rst_pin_oe, rst_pin_out, supply_below_threshold;
    logic conversion_start_input_n, comparator0_n, missing_clock_event, watchdog_overflow;
    logic bus_wr, bus_rd, irq, core_halt, port_latch_force, pc_clear, osc_internal_sel, wdt_enable, wdt_restart;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, port_latch_value, reset_source_register, rdv;
    logic [15:0] pc_value;
    logic [1:0] osc_freq_sel;
    logic [2:0] wdt_interval;
    int n_errors = 0;
    int n_compared = 0;
    int n_oe, n;

    mcu_reset_sequencer #(.POR_TIMEOUT_CYCLES(POR), .PIN_EXIT_CYCLES(12), .SRC_EXIT_CYCLES(4)) i_dut (.sys_clk,
        .reset_n, .supply_below_threshold, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .conversion_start_input_n,
        .comparator0_n, .missing_clock_event, .watchdog_overflow, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .irq, .core_halt, .sfr_load_defaults(), .irq_disable(), .timers_disable(),
        .stack_pointer_reset(), .data_ram_write_block(), .port_latch_force, .port_latch_value, .pc_clear,
        .pc_value, .osc_internal_sel, .osc_freq_sel, .wdt_enable, .wdt_restart, .wdt_interval,
        .reset_source_register);
    reset_env_model i_env (.sys_clk, .rst_pin_oe, .rst_pin_out, .ext_pull, .supply_low_req, .rst_pin_in,
        .supply_below_threshold);

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("compares %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one-cycle strobes; a gap cycle follows each so no strobe is set twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // bounded wait for release; also tallies cycles with the pin driven
    task automatic wait_exit(output int cnt);
        cnt = 0;
        n_oe = 0;
        while (core_halt !== 1'b0 && cnt < 1000)
        begin
            @(posedge sys_clk);
            #1 cnt++;
            if (rst_pin_oe === 1'b1) n_oe++;
        end
        if (core_halt !== 1'b0)
        begin
            n_errors++;
            $display("release wait ran out");
            summarize();
        end
    endtask

    // defaults that every reset exit must present
    task automatic check_exit;
        check(pc_clear, 1'b1);
        check(pc_value, 16'h0000);
        check({osc_internal_sel, osc_freq_sel}, 3'b100);
        check({wdt_enable, wdt_restart, wdt_interval}, 5'h1F);
        check(port_latch_value, 8'hFF);
    endtask

    task automatic t_power_on;
        #1 check(core_halt, 1'b1);
        @(posedge sys_clk);
        supply_low_req <= 1'b0;
        wait_exit(n);
        check(n_oe >= POR, 1'b1);
        check(reset_source_register, 8'h02);
        check_exit();
        $display("test power_on done");
    endtask

    // status sticky, mask gates the level, write one clears, unmapped reads zero
    task automatic t_irq;
        rd(8'h08, rdv);
        check(rdv, 8'h01);
        wr(8'h0C, 8'h01);
        #1 check(irq, 1'b1);
        wr(8'h08, 8'h01);
        #1 check(irq, 1'b0);
        rd(8'h10, rdv);
        check(rdv, 8'h00);
        $display("test irq done");
    endtask

    task automatic t_pin;
        @(posedge sys_clk);
        ext_pull <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check({core_halt, port_latch_force}, 2'b11);
        @(posedge sys_clk);
        ext_pull <= 1'b0;
        wait_exit(n);
        check(n >= 13, 1'b1);
        check(n_oe, 0);
        check(reset_source_register, 8'h01);
        check_exit();
        rd(8'h00, rdv);
        check(rdv, 8'h01);
        $display("test pin done");
    endtask

    task automatic drive_src(input int i, input logic v);
        case (i)
            0: watchdog_overflow <= v;
            1: missing_clock_event <= v;
            2: comparator0_n <= !v;
            default: conversion_start_input_n <= !v;
        endcase
    endtask

    // watchdog, missing clock, comparator, conversion start; the comparator is ignored before it is enabled
    task automatic t_sources;
        logic [7:0] exp_flag [4] = '{8'h08, 8'h04, 8'h20, 8'h40};
        @(posedge sys_clk);
        drive_src(2, 1'b1);
        repeat (3) @(posedge sys_clk);
        drive_src(2, 1'b0);
        #1 check(core_halt, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            // non-default clock settings, so the next exit must really restore them
            if (i == 1)
            begin
                wr(8'h04, 8'h0F);
                rd(8'h04, rdv);
                check({rdv, osc_internal_sel, osc_freq_sel}, {8'h0F, 3'b011});
            end
            if (i > 1) wr(8'h00, exp_flag[i]);
            @(posedge sys_clk);
            drive_src(i, 1'b1);
            repeat (3) @(posedge sys_clk);
            drive_src(i, 1'b0);
            #1 check(core_halt, 1'b1);
            wait_exit(n);
            check(reset_source_register, exp_flag[i]);
            check(n_oe, 0);
            check_exit();
        end
        $display("test sources done");
    endtask

    task automatic t_soft_por;
        wr(8'h00, 8'h02);
        @(posedge sys_clk);
        #1 check({core_halt, rst_pin_oe, rst_pin_in}, 3'b110);
        wait_exit(n);
        check(n_oe >= POR - 2, 1'b1);
        check(reset_source_register, 8'h02);
        check_exit();
        $display("test soft_por done");
    endtask

    task automatic t_supply;
        @(posedge sys_clk);
        supply_low_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 check({core_halt, rst_pin_oe, rst_pin_in}, 3'b110);
        @(posedge sys_clk);
        supply_low_req <= 1'b0;
        wait_exit(n);
        check(n_oe >= POR, 1'b1);
        check(reset_source_register, 8'h02);
        check_exit();
        $display("test supply done");
    endtask

    initial
    begin
        {reset_n, ext_pull, missing_clock_event, watchdog_overflow, bus_wr, bus_rd} = 6'h00;
        {supply_low_req, conversion_start_input_n, comparator0_n} = 3'h7;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        t_power_on();
        t_irq();
        t_pin();
        t_sources();
        t_soft_por();
        t_supply();
        summarize();
    end
endmodule
